// ==== supv_pkg.sv ====
// constants, field layout and state codes of the supervision block
// assumes a single 40 MHz relay clock and a word-wide Avalon-MM slave
package supv_pkg;
   // register byte offsets
   localparam logic [5:0] CTRL_OFS = 6'h00;
   localparam logic [5:0] BF_DLY_OFS = 6'h04;
   localparam logic [5:0] TCS_DLY_OFS = 6'h08;
   localparam logic [5:0] LOP_DLY_OFS = 6'h0C;
   localparam logic [5:0] CTS_OFS = 6'h10;
   localparam logic [5:0] RATING_OFS = 6'h14;
   localparam logic [5:0] MASK_OFS = 6'h18;
   localparam logic [5:0] STATUS_OFS = 6'h1C;
   localparam logic [5:0] ACK_OFS = 6'h20;
   // control, CT-supervision and mask field positions
   localparam int TRIG_LSB = 0;
   localparam int BOTH_AUX_BIT = 2;
   localparam int BLK_EN_BIT = 3;
   localparam int WSEL_BIT = 4;
   localparam int CB_ASGN_BIT = 5;
   localparam int CTS_EN_BIT = 6;
   localparam int KD_LSB = 16;
   localparam int MCS_LSB = 8;
   localparam int XTRIG_LSB = 16;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [23:0] DLY_RST = 24'h00_00FF;
   localparam logic [31:0] CTS_RST = 32'h0000_0100;
   localparam logic [31:0] RATING_RST = 32'h0101_0101;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   // supervision limits
   localparam logic [7:0] SEQ_RATIO_LIM = 8'h28; // percent
   localparam logic [7:0] RES_CUR_LIM = 8'h0A; // hundredths of rated
   localparam int KD_FRAC = 4;
   localparam int DLY_W = 24;
   typedef enum logic [1:0] {
      TRIG_ALL = 2'h0, TRIG_EXT = 2'h1, TRIG_CUR = 2'h2, TRIG_NONE = 2'h3
   } trig_mode_t;
   typedef enum logic [1:0] {
      BF_IDLE = 2'h0, BF_RUN = 2'h1, BF_TRIP = 2'h3, BF_REJ = 2'h2
   } bf_state_t;
endpackage

// ==== supv_delay_timer.sv ====
// qualifying-condition delay timer shared by breaker-failure, trip-circuit and voltage-loss supervision
// assumes cond and delay come from logic on the same clock
`timescale 1ns/1ps
module supv_delay_timer import supv_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic cond,
   input wire logic [DLY_W-1:0] delay,
   output logic expired
);
   logic [DLY_W-1:0] cnt_q;
   logic exp_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else if (ce) begin
         if (!cond) begin
            cnt_q <= '0;
            exp_q <= 1'b0;
         end else if (cnt_q == delay) begin
            exp_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
   assign expired = exp_q;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   timer_restart_a: assert property (ce && !cond |=> !expired)
      else $error("timer kept running after condition dropped");
   timer_early_a: assert property ($rose(expired) |-> $past(cnt_q) == $past(delay))
      else $error("timer expired before its delay");
endmodule // supv_delay_timer

// ==== supv_core.sv ====
// supervision logic: breaker failure, trip circuit, CT and voltage loss
// assumes Avalon-MM master on core_clk; pins are asynchronous, measurements synchronous
// Overview of operation
// - lockout latches with breaker-fail trip, acknowledged
// - lockout inhibits breaker close command
// - trigger mode selects all, external, current, none
// - three extra triggers start breaker-fail supervision
// - mode none leaves only extra triggers
// - trip after delay unless breaker opened
// - delay timer ignores trigger drop, stops on opening
// - one aux evaluates when closed; two always
// - broken trip circuit alarms after delay
// - both supervising inputs low means broken
// - CT alarm when residual mismatch reaches limit
// - earth ratio derived from CT ratings
// - limit rises linearly with largest phase current
// - voltage loss alarm after set delay
// - voltage loss needs all listed conditions together
// - assigned overcurrent pickups inhibit voltage loss
// - block only when block enable set
// - supervised elements blocked while block asserted
// - winding select picks measured side
// - fuse input flags transformer fuse failure
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module supv_core import supv_pkg::*; (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic tripAll,
   input wire logic tripExternal,
   input wire logic tripCurrent,
   input wire logic [2:0] extraTrigger,
   input wire logic breakerOpenDetected,
   input wire logic closeRequest,
   output logic breakerCloseOut,
   output logic bfTrip,
   output logic lockout,
   input wire logic brkClosedAuxPin,
   input wire logic [1:0] tcsInputPin,
   input wire logic fuseInputPin,
   input wire logic signed [15:0] phaseCurA,
   input wire logic signed [15:0] phaseCurB,
   input wire logic signed [15:0] phaseCurC,
   input wire logic signed [15:0] earthCur,
   input wire logic [1:0] vPhaseLow,
   input wire logic [1:0] vResidLow,
   input wire logic [7:0] seqRatioW0,
   input wire logic [7:0] seqRatioW1,
   input wire logic [1:0] curBelow,
   input wire logic [7:0] resCurW0,
   input wire logic [7:0] resCurW1,
   input wire logic [7:0] ocPickup,
   input wire logic deadBus,
   output logic tcsAlarm,
   output logic ctsAlarm,
   output logic lopAlarm,
   output logic fuseFail,
   output logic voltageLossBlock,
   output logic [7:0] elementBlock
);
   logic [31:0] ctrl_q, bfDly_q, tcsDly_q, lopDly_q, cts_q, rating_q, mask_q;
   logic [31:0] status, rdMux;
   logic ack_q, wrStrobe, ackPulse;
   logic [3:0] pinMeta_q, pinSync_q;
   logic brkClosed;
   trig_mode_t trigMode;
   bf_state_t bfState_q;
   logic bfTrigger, bfExpired, bfTrip_q, lockout_q;
   logic tcsBroken, tcsExp;
   logic ctsCond, ctsAlarm_q;
   logic lopCond, lopExp, fuse_q;

   // one wait state per access
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wrStrobe = avs_write & ack_q & ce;
   assign ackPulse = wrStrobe && avs_address == ACK_OFS && avs_writedata[0];
   always_ff @(posedge core_clk) begin
      if (rst) ack_q <= 1'b0;
      else if (ce) ack_q <= (avs_read | avs_write) & ~ack_q;
   end

   // byte-lane merge of write data
   function automatic logic [31:0] merge(input logic [31:0] old);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (avs_byteenable[i]) r[8*i +: 8] = avs_writedata[8*i +: 8];
      return r;
   endfunction

   // settings registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_q <= CTRL_RST;
         bfDly_q <= {8'h00, DLY_RST};
         tcsDly_q <= {8'h00, DLY_RST};
         lopDly_q <= {8'h00, DLY_RST};
         cts_q <= CTS_RST;
         rating_q <= RATING_RST;
         mask_q <= MASK_RST;
      end else if (wrStrobe) begin
         case (avs_address)
            CTRL_OFS: ctrl_q <= merge(ctrl_q) & 32'h0000_007F;
            BF_DLY_OFS: bfDly_q <= merge(bfDly_q) & 32'h00FF_FFFF;
            TCS_DLY_OFS: tcsDly_q <= merge(tcsDly_q) & 32'h00FF_FFFF;
            LOP_DLY_OFS: lopDly_q <= merge(lopDly_q) & 32'h00FF_FFFF;
            CTS_OFS: cts_q <= merge(cts_q) & 32'h00FF_FFFF;
            RATING_OFS: rating_q <= merge(rating_q);
            MASK_OFS: mask_q <= merge(mask_q) & 32'h0007_FFFF;
            default: ;
         endcase
      end
   end

   // live state for software
   assign status = {24'h00_0000, fuse_q, voltageLossBlock, lopExp, ctsAlarm_q,
                    tcsExp, lockout_q, bfTrip_q, bfState_q == BF_REJ};
   always_comb begin
      case (avs_address)
         CTRL_OFS: rdMux = ctrl_q;
         BF_DLY_OFS: rdMux = bfDly_q;
         TCS_DLY_OFS: rdMux = tcsDly_q;
         LOP_DLY_OFS: rdMux = lopDly_q;
         CTS_OFS: rdMux = cts_q;
         RATING_OFS: rdMux = rating_q;
         MASK_OFS: rdMux = mask_q;
         STATUS_OFS: rdMux = status;
         default: rdMux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (rst) avs_readdata <= 32'h0000_0000;
      else if (ce && avs_read && !ack_q) avs_readdata <= rdMux;
   end

   // two-stage synchroniser for contact inputs
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
      end else if (ce) begin
         pinMeta_q <= {fuseInputPin, tcsInputPin, brkClosedAuxPin};
         pinSync_q <= pinMeta_q;
      end
   end
   assign brkClosed = pinSync_q[0];

   // trigger selection
   assign trigMode = trig_mode_t'(ctrl_q[TRIG_LSB +: 2]);
   always_comb begin
      case (trigMode)
         TRIG_ALL: bfTrigger = tripAll;
         TRIG_EXT: bfTrigger = tripExternal;
         TRIG_CUR: bfTrigger = tripCurrent;
         default: bfTrigger = 1'b0;
      endcase
      bfTrigger = bfTrigger | (|(extraTrigger & mask_q[XTRIG_LSB +: 3]));
   end

   // breaker-failure delay runs only while armed
   supv_delay_timer bfTimer (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .cond(bfState_q == BF_RUN && !breakerOpenDetected),
      .delay(bfDly_q[DLY_W-1:0]),
      .expired(bfExpired)
   );

   // breaker-failure sequence
   always_ff @(posedge core_clk) begin
      if (rst) bfState_q <= BF_IDLE;
      else if (ce) begin
         case (bfState_q)
            BF_IDLE: if (bfTrigger) bfState_q <= BF_RUN;
            BF_RUN: begin
               if (breakerOpenDetected) bfState_q <= BF_REJ;
               else if (bfExpired) bfState_q <= BF_TRIP;
            end
            BF_TRIP: if (!bfTrigger) bfState_q <= BF_IDLE;
            BF_REJ: if (!bfTrigger) bfState_q <= BF_IDLE;
            default: bfState_q <= BF_IDLE;
         endcase
      end
   end

   // trip output and latched lockout
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bfTrip_q <= 1'b0;
         lockout_q <= 1'b0;
      end else if (ce) begin
         bfTrip_q <= (bfState_q == BF_RUN && !breakerOpenDetected && bfExpired)
                     || (bfState_q == BF_TRIP && bfTrigger);
         if (bfState_q == BF_RUN && !breakerOpenDetected && bfExpired) lockout_q <= 1'b1;
         else if (ackPulse) lockout_q <= 1'b0;
      end
   end
   assign bfTrip = bfTrip_q;
   assign lockout = lockout_q;
   assign breakerCloseOut = closeRequest & ~lockout_q;

   assign tcsBroken = ctrl_q[BOTH_AUX_BIT] ? (pinSync_q[1] == 1'b0 && pinSync_q[2] == 1'b0)
                                           : (brkClosed && !pinSync_q[1]);
   supv_delay_timer tcsTimer (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .cond(tcsBroken),
      .delay(tcsDly_q[DLY_W-1:0]),
      .expired(tcsExp)
   );
   assign tcsAlarm = tcsExp;

   // CT supervision arithmetic, cross-multiplied to avoid a divider
   logic signed [17:0] sumPh;
   logic [15:0] absA, absB, absC, iMax;
   logic [15:0] phScale, eaScale;
   logic signed [35:0] resid;
   logic [35:0] residMag;
   logic [23:0] kdProd;
   logic [20:0] limit;
   logic [36:0] limitScaled;
   always_comb begin
      sumPh = 18'(phaseCurA) + 18'(phaseCurB) + 18'(phaseCurC);
      absA = phaseCurA[15] ? 16'(-phaseCurA) : 16'(phaseCurA);
      absB = phaseCurB[15] ? 16'(-phaseCurB) : 16'(phaseCurB);
      absC = phaseCurC[15] ? 16'(-phaseCurC) : 16'(phaseCurC);
      iMax = (absA > absB) ? absA : absB;
      iMax = (iMax > absC) ? iMax : absC;
      phScale = rating_q[7:0] * rating_q[31:24];
      eaScale = rating_q[23:16] * rating_q[15:8];
      resid = 36'(sumPh * $signed({1'b0, phScale})) + 36'(earthCur * $signed({1'b0, eaScale}));
      residMag = resid[35] ? 36'(-resid) : 36'(resid);
      kdProd = cts_q[KD_LSB +: 8] * iMax;
      limit = 21'(cts_q[15:0]) + 21'(kdProd >> KD_FRAC);
      limitScaled = limit * phScale;
   end
   assign ctsCond = ctrl_q[CTS_EN_BIT] && ({1'b0, residMag} >= limitScaled);
   always_ff @(posedge core_clk) begin
      if (rst) ctsAlarm_q <= 1'b0;
      else if (ce) ctsAlarm_q <= ctsCond;
   end
   assign ctsAlarm = ctsAlarm_q;

   // voltage-loss evaluation on the selected winding
   logic wsel, seqHigh, resLow, cbOk;
   always_comb begin
      wsel = ctrl_q[WSEL_BIT];
      seqHigh = (wsel ? seqRatioW1 : seqRatioW0) > SEQ_RATIO_LIM;
      resLow = (wsel ? resCurW1 : resCurW0) < RES_CUR_LIM;
      cbOk = !ctrl_q[CB_ASGN_BIT] || brkClosed;
      lopCond = vPhaseLow[wsel] && (vResidLow[wsel] || seqHigh) && curBelow[wsel]
                && resLow && !(|(ocPickup & mask_q[7:0])) && cbOk && !deadBus;
   end
   supv_delay_timer lopTimer (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .cond(lopCond),
      .delay(lopDly_q[DLY_W-1:0]),
      .expired(lopExp)
   );
   assign lopAlarm = lopExp;

   always_ff @(posedge core_clk) begin
      if (rst) fuse_q <= 1'b0;
      else if (ce) fuse_q <= pinSync_q[3];
   end
   assign fuseFail = fuse_q;

   assign voltageLossBlock = ctrl_q[BLK_EN_BIT] & (lopExp | fuse_q);
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : gBlk
         assign elementBlock[g] = voltageLossBlock & mask_q[MCS_LSB + g];
      end
   endgenerate

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   lockout_with_trip_a: assert property ($rose(bfTrip_q) |-> lockout_q)
      else $error("trip raised without lockout");
   close_inhibit_a: assert property (lockout_q |-> !breakerCloseOut)
      else $error("close passed while locked out");
   trig_none_a: assert property (ce && bfState_q == BF_IDLE && trigMode == TRIG_NONE &&
      (extraTrigger & mask_q[18:16]) == 3'h0 |=> bfState_q == BF_IDLE)
      else $error("supervision started with no trigger");
   bf_trip_cause_a: assert property ($rose(bfTrip_q) |-> $past(bfState_q) == BF_RUN
      && !$past(breakerOpenDetected))
      else $error("trip without elapsed delay");
   bf_hold_a: assert property (ce && bfState_q == BF_RUN && !breakerOpenDetected
      && !bfExpired |=> bfState_q == BF_RUN)
      else $error("timer abandoned early");
   bf_open_stop_a: assert property (ce && bfState_q == BF_RUN && breakerOpenDetected
      |=> bfState_q == BF_REJ ##1 !$rose(bfTrip_q))
      else $error("trip after breaker opened");
   tcs_one_aux_a: assert property (!ctrl_q[BOTH_AUX_BIT] && !brkClosed |-> !tcsBroken)
      else $error("trip circuit evaluated while open");
   tcs_delay_a: assert property ($rose(tcsAlarm) |-> $past(tcsBroken, 1))
      else $error("trip circuit alarm without cause");
   cts_alarm_a: assert property (ce && ctsCond |=> ctsAlarm)
      else $error("ct alarm missed");
   lop_block_en_a: assert property (!ctrl_q[BLK_EN_BIT] |-> !voltageLossBlock
      && elementBlock == 8'h00)
      else $error("block without enable");
   elem_block_a: assert property (voltageLossBlock |-> elementBlock == mask_q[15:8])
      else $error("element block mismatch");
   oc_inhibit_a: assert property ((ocPickup & mask_q[7:0]) != 8'h00 |-> !lopCond)
      else $error("pickup failed to inhibit");
   bf_trip_c: cover property (bfState_q == BF_RUN ##[1:1000] bfTrip_q);
   bf_rej_c: cover property (bfState_q == BF_REJ);
   tcs_alarm_c: cover property ($rose(tcsAlarm));
   lop_block_c: cover property ($rose(voltageLossBlock));
endmodule // supv_core

// ==== supv_breaker_model.sv ====
// far-side model: breaker auxiliary contacts, trip-circuit inputs and VT fuse contact
// assumes the bench changes its controls right after a rising clock edge
`timescale 1ns/1ps
module supv_breaker_model (
   input wire logic breakerClosed,
   input wire logic wireBroken,
   input wire logic supplyLost,
   input wire logic bothAux,
   input wire logic fuseOpen,
   output logic brkClosedAuxPin,
   output logic [1:0] tcsInputPin,
   output logic fuseInputPin
);
   assign brkClosedAuxPin = breakerClosed;
   // supervision currents, both lost with supply
   assign tcsInputPin[0] = breakerClosed & ~wireBroken & ~supplyLost;
   assign tcsInputPin[1] = bothAux & ~breakerClosed & ~wireBroken & ~supplyLost;
   assign fuseInputPin = fuseOpen;
endmodule // supv_breaker_model

// ==== protection_supervision_logic_tb_top.sv ====
// self-checking bench for the supervision core: bus tasks and scenario sequences
// assumes supv_pkg and supv_core as delivered, one 40 MHz clock
`timescale 1ns/1ps
module protection_supervision_logic_tb_top import supv_pkg::*;;
   localparam int BFD = 4;
   logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rdData;
   logic [3:0] avs_byteenable = 4'hF;
   logic avs_waitrequest, breakerCloseOut, bfTrip, lockout, brkClosedAuxPin, fuseInputPin;
   logic [5:0] srcVec = 6'h00;
   wire tripAll = srcVec[0];
   wire tripExternal = srcVec[1];
   wire tripCurrent = srcVec[2];
   wire [2:0] extraTrigger = srcVec[5:3];
   // dead bus held until the voltage-loss scenarios so no stray alarm shows in status
   logic breakerOpenDetected = 1'b0, closeRequest = 1'b0, deadBus = 1'b1;
   logic [1:0] tcsInputPin;
   logic breakerClosed = 1'b1, wireBroken = 1'b0, supplyLost = 1'b0, bothAux = 1'b1;
   logic fuseOpen = 1'b0;
   logic signed [15:0] phaseCurA = 16'sh0, phaseCurB = 16'sh0, phaseCurC = 16'sh0;
   logic signed [15:0] earthCur = 16'sh0;
   logic [1:0] vPhaseLow = 2'h1, vResidLow = 2'h1, curBelow = 2'h1;
   logic [7:0] seqRatioW0 = 8'h00, seqRatioW1 = 8'h00, resCurW0 = 8'h00, resCurW1 = 8'h00;
   logic [7:0] ocPickup = 8'h00, elementBlock;
   logic tcsAlarm, ctsAlarm, lopAlarm, fuseFail, voltageLossBlock;
   int failures = 0, compares = 0;
   logic [5:0] rstOfs [9] = '{CTRL_OFS, BF_DLY_OFS, TCS_DLY_OFS, LOP_DLY_OFS, CTS_OFS,
      RATING_OFS, MASK_OFS, STATUS_OFS, 6'h24};
   logic [31:0] rstVal [9] = '{CTRL_RST, {8'h00, DLY_RST}, {8'h00, DLY_RST}, {8'h00, DLY_RST},
      CTS_RST, RATING_RST, MASK_RST, 32'h0, 32'h0};

   // clock at 25 ns period
   always #12.5 core_clk = ~core_clk;

   supv_core uut (.core_clk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .tripAll, .tripExternal, .tripCurrent,
      .extraTrigger, .breakerOpenDetected, .closeRequest, .breakerCloseOut, .bfTrip, .lockout,
      .brkClosedAuxPin, .tcsInputPin, .fuseInputPin, .phaseCurA, .phaseCurB, .phaseCurC,
      .earthCur, .vPhaseLow, .vResidLow, .seqRatioW0, .seqRatioW1, .curBelow, .resCurW0,
      .resCurW1, .ocPickup, .deadBus, .tcsAlarm, .ctsAlarm, .lopAlarm, .fuseFail,
      .voltageLossBlock, .elementBlock);

   supv_breaker_model farSide (.breakerClosed, .wireBroken, .supplyLost, .bothAux, .fuseOpen,
      .brkClosedAuxPin, .tcsInputPin, .fuseInputPin);

   // verdict and end of run
   task give_verdict;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task checkVal(input string nm, input logic [31:0] expV, input logic [31:0] gotV);
      compares++;
      if (gotV !== expV) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, expV, gotV);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task look;
      @(negedge core_clk);
   endtask

   // one Avalon transfer held until waitrequest is seen low
   task avXfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) begin
         failures++;
         $display("[FAIL] bus answer expected 0 seen 1");
         give_verdict;
      end
      rdData = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task rdChk(input string nm, input logic [5:0] a, input logic [31:0] e);
      avXfer(1'b0, a, 32'h0);
      checkVal(nm, e, rdData);
   endtask

   // start one trigger source, pulsed or held, then check the latch and acknowledge
   task bfRun(input int src, input logic held, input logic expLock, input string nm);
      @(posedge core_clk);
      srcVec <= 6'h01 << src;
      if (!held) begin
         @(posedge core_clk);
         srcVec <= 6'h00;
      end
      cyc(BFD + 6);
      look;
      checkVal(nm, expLock, lockout);
      cyc(1);
      srcVec <= 6'h00;
      avXfer(1'b1, ACK_OFS, 32'h1);
      cyc(3);
   endtask

   task tcsChk(input logic cl, br, sl, ba, input int hold, input logic e, input string nm);
      @(posedge core_clk);
      breakerClosed <= cl;
      wireBroken <= br;
      supplyLost <= sl;
      bothAux <= ba;
      cyc(hold);
      look;
      checkVal(nm, e, tcsAlarm);
      cyc(1);
      wireBroken <= 1'b0;
      supplyLost <= 1'b0;
      cyc(4);
   endtask

   task ctsChk(input logic signed [15:0] a, b, c, g, input logic e, input string nm);
      @(posedge core_clk);
      phaseCurA <= a;
      phaseCurB <= b;
      phaseCurC <= c;
      earthCur <= g;
      cyc(3);
      look;
      checkVal(nm, e, ctsAlarm);
   endtask

   task lopChk(input logic [31:0] ctl, input logic [1:0] vrl, input logic [7:0] seq, res, ocp,
         input logic dead, e, input logic [7:0] blk, input string nm);
      avXfer(1'b1, CTRL_OFS, ctl);
      vResidLow <= vrl;
      seqRatioW0 <= seq;
      resCurW0 <= res;
      ocPickup <= ocp;
      deadBus <= dead;
      cyc(12);
      look;
      checkVal(nm, e, lopAlarm);
      checkVal(nm, blk, elementBlock);
      checkVal(nm, blk != 8'h00, voltageLossBlock);
      cyc(1);
   endtask

   // bound on the whole run
   initial begin
      cyc(60000);
      failures++;
      give_verdict;
   end

   // main sequence
   initial begin
      cyc(2);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) rdChk("reset value", rstOfs[i], rstVal[i]);
      avXfer(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
      avXfer(1'b1, 6'h24, 32'hFFFF_FFFF);
      rdChk("read only status", STATUS_OFS, 32'h0);
      rdChk("unmapped", 6'h24, 32'h0);
      avs_byteenable <= 4'h1;
      avXfer(1'b1, BF_DLY_OFS, 32'hFFFF_FF04); // only the low lane lands
      avs_byteenable <= 4'hF;
      rdChk("delay readback", BF_DLY_OFS, BFD);
      for (int m = 0; m < 4; m++) begin
         avXfer(1'b1, CTRL_OFS, m);
         for (int s = 0; s < 3; s++) bfRun(s, 1'b0, s == m, "mode lockout");
      end
      avXfer(1'b1, MASK_OFS, 32'h0007_0000);
      for (int s = 3; s < 6; s++) bfRun(s, 1'b0, 1'b1, "extra trigger");
      avXfer(1'b1, MASK_OFS, 32'h0);
      bfRun(3, 1'b1, 1'b0, "extra disabled");
      // held trigger, delay and close inhibit
      avXfer(1'b1, CTRL_OFS, 32'h0);
      closeRequest <= 1'b1;
      @(posedge core_clk);
      srcVec <= 6'h01;
      cyc(BFD);
      look;
      checkVal("early trip", 1'b0, bfTrip);
      checkVal("early close", 1'b1, breakerCloseOut);
      cyc(4);
      look;
      checkVal("trip", 1'b1, bfTrip);
      checkVal("lockout", 1'b1, lockout);
      checkVal("close inhibit", 1'b0, breakerCloseOut);
      rdChk("status trip", STATUS_OFS, 32'h06);
      srcVec <= 6'h00;
      cyc(3);
      rdChk("status latched", STATUS_OFS, 32'h04);
      avXfer(1'b1, ACK_OFS, 32'h1);
      look;
      checkVal("acknowledged", 1'b0, lockout);
      checkVal("close free", 1'b1, breakerCloseOut);
      cyc(1);
      srcVec <= 6'h01;
      cyc(2);
      breakerOpenDetected <= 1'b1;
      cyc(BFD + 6);
      look;
      checkVal("rejected lockout", 1'b0, lockout);
      rdChk("status rejected", STATUS_OFS, 32'h01);
      srcVec <= 6'h00;
      breakerOpenDetected <= 1'b0;
      cyc(3);
      rdChk("status idle", STATUS_OFS, 32'h0);
      // trip circuit supervision with both contacts, then one
      avXfer(1'b1, TCS_DLY_OFS, 32'h8);
      avXfer(1'b1, CTRL_OFS, 32'h04);
      tcsChk(1'b1, 1'b0, 1'b0, 1'b1, 20, 1'b0, "tcs healthy");
      tcsChk(1'b1, 1'b0, 1'b1, 1'b1, 20, 1'b1, "tcs supply");
      tcsChk(1'b0, 1'b1, 1'b0, 1'b1, 20, 1'b1, "tcs open broken");
      tcsChk(1'b1, 1'b1, 1'b0, 1'b1, 6, 1'b0, "tcs short");
      tcsChk(1'b1, 1'b1, 1'b0, 1'b1, 6, 1'b0, "tcs restart");
      avXfer(1'b1, CTRL_OFS, 32'h0);
      tcsChk(1'b0, 1'b1, 1'b0, 1'b0, 20, 1'b0, "tcs one open");
      tcsChk(1'b1, 1'b1, 1'b0, 1'b0, 20, 1'b1, "tcs one closed");
      // CT supervision limit, dynamic factor and earth ratio
      avXfer(1'b1, CTRL_OFS, 32'h40);
      ctsChk(16'sh0064, -16'sh0032, -16'sh0032, 16'sh0, 1'b0, "cts balanced");
      ctsChk(16'sh0164, -16'sh0032, -16'sh0032, 16'sh0, 1'b1, "cts at limit");
      ctsChk(16'sh0163, -16'sh0032, -16'sh0032, 16'sh0, 1'b0, "cts below");
      avXfer(1'b1, CTS_OFS, 32'h0010_0100);
      ctsChk(16'sh0190, -16'sh0032, -16'sh0032, 16'sh0, 1'b0, "cts kd one");
      avXfer(1'b1, CTS_OFS, 32'h0001_0100);
      ctsChk(16'sh0190, -16'sh0032, -16'sh0032, 16'sh0, 1'b1, "cts kd small");
      avXfer(1'b1, CTS_OFS, 32'h0000_0100);
      ctsChk(16'sh02BC, -16'sh0032, -16'sh0032, -16'sh012C, 1'b1, "cts ratio one");
      avXfer(1'b1, RATING_OFS, 32'h0102_0101);
      ctsChk(16'sh02BC, -16'sh0032, -16'sh0032, -16'sh012C, 1'b0, "cts ratio two");
      avXfer(1'b1, CTRL_OFS, 32'h0);
      ctsChk(16'sh02BC, -16'sh0032, -16'sh0032, 16'sh0, 1'b0, "cts disabled");
      // voltage loss conditions, blocking and winding choice
      avXfer(1'b1, LOP_DLY_OFS, 32'h4);
      avXfer(1'b1, MASK_OFS, 32'h0000_0501);
      lopChk(32'h08, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 8'h05, "lop all");
      lopChk(32'h08, 2'h1, 8'h00, 8'h0A, 8'h00, 1'b0, 1'b0, 8'h00, "lop residual");
      lopChk(32'h08, 2'h0, 8'h29, 8'h00, 8'h00, 1'b0, 1'b1, 8'h05, "lop ratio");
      lopChk(32'h08, 2'h0, 8'h28, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, "lop ratio 40");
      lopChk(32'h08, 2'h1, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 8'h00, "lop blocker");
      lopChk(32'h08, 2'h1, 8'h00, 8'h00, 8'h02, 1'b0, 1'b1, 8'h05, "lop other oc");
      lopChk(32'h08, 2'h1, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00, "lop dead bus");
      lopChk(32'h00, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00, "lop no block");
      lopChk(32'h18, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, "lop winding");
      breakerClosed <= 1'b0;
      lopChk(32'h28, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00, "lop cb open");
      breakerClosed <= 1'b1;
      lopChk(32'h28, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1, 8'h05, "lop cb closed");
      // fuse contact with measured conditions blocked
      lopChk(32'h08, 2'h1, 8'h00, 8'h00, 8'h01, 1'b0, 1'b0, 8'h00, "lop pre fuse");
      cyc(1);
      fuseOpen <= 1'b1;
      cyc(5);
      look;
      checkVal("fuse fail", 1'b1, fuseFail);
      checkVal("fuse block", 8'h05, elementBlock);
      give_verdict;
   end
endmodule // protection_supervision_logic_tb_top
